/* inc/pscr_defines.svh */
// register offsets, field positions, reset values and timing counts
`ifndef PSCR_DEFINES_SVH
`define PSCR_DEFINES_SVH
`define PSCR_ADDR_W 10
`define PSCR_OFF_SYNTH 10'h034
`define PSCR_OFF_REF_DIV 10'h035
`define PSCR_OFF_POST_DIV 10'h036
`define PSCR_OFF_FLAGS 10'h037
`define PSCR_OFF_CLKSEL 10'h039
`define PSCR_OFF_OSC 10'h2fa
`define PSCR_OFF_PROTECT 10'h2fb
`define PSCR_OFF_LOCKSIM 10'h2fd
`define PSCR_RST_SYNTH 8'h5f
`define PSCR_RST_REF_DIV 8'h00
`define PSCR_RST_POST_DIV 8'h03
`define PSCR_RST_CLKSEL 8'h80
`define PSCR_RST_OSC 8'h00
`define PSCR_RST_PROTECT 8'h00
`define PSCR_SEL_BIT 7
`define PSCR_EXT_OSC_BIT 7
`define PSCR_PROTECT_BIT 0
`define PSCR_LOCK_BIT 3
`define PSCR_QUALIFIED_BIT 0
`define PSCR_LOCK_US 100
`define PSCR_CLK_MHZ 200
`define PSCR_LOCK_CYC (`PSCR_LOCK_US * `PSCR_CLK_MHZ)
`define PSCR_QUAL_CYC 64
`define PSCR_FILT_FIXED 2'b00
`define PSCR_UNLOCK_DIV 5'h03
`endif

/* inc/pscr_pkg.sv */
// types shared by the synthesizer configuration block
package pscr_pkg;
  typedef enum logic [1:0] {
    PSCR_ST_IDLE = 2'b00,
    PSCR_ST_SETTLE = 2'b01,
    PSCR_ST_LOCKED = 2'b10
  } pscr_state_e;
  typedef logic [7:0] pscr_byte_t;
endpackage

/* core/pscr_settle_cnt.sv */
// settle timer: counts down a load value, flags expiry
module pscr_settle_cnt #(
  parameter int CNT_W = 16
) (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_in,
  // control
  input wire logic load_in,
  input wire logic [CNT_W-1:0] value_in,
  // status
  output logic done_out
);
  if (CNT_W < 1) begin : g_bad_w
    $error("pscr_settle_cnt: counter width must be positive");
  end

  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic done_r;
  logic done_nxt;

  always_comb begin
    cnt_nxt = cnt_r;
    done_nxt = 1'b0;
    if (load_in) begin
      cnt_nxt = value_in;
    end else if (cnt_r != '0) begin
      cnt_nxt = cnt_r - 1'b1;
      done_nxt = (cnt_r == {{(CNT_W-1){1'b0}}, 1'b1});
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      cnt_r <= '0;
      done_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      done_r <= done_nxt;
    end
  end

  assign done_out = done_r;
endmodule

/* core/pscr_synth_cfg.sv */
// synthesizer configuration registers, lock model and divider outputs
//
// Added by the designer: the address-and-strobe port.
`include "pscr_defines.svh"

// Overview of operation
// - multiplier and reference divider writes need protect clear, loop clock selected
// - accepted multiplier or reference divider write clears lock and qualified status
// - locked oscillator runs at 2 x reference x (multiplier + 1), offset 0x34
// - reference is oscillator over (divisor + 1), or internal 1 MHz clock
// - with internal reference the filter stays at the 1-2 MHz setting
// - post divider writes need loop clock selected
// - output is oscillator over (post divisor + 1) when locked, else over 4
// - with loop clock selected bus clock is half the output clock
// - reset targets 64 MHz oscillator, post divider 3, 16 MHz out, 8 MHz bus
// - lock status reads 1 when oscillator within tolerance of target
module pscr_synth_cfg #(
  parameter int LOCK_CYC = `PSCR_LOCK_CYC,
  parameter int QUAL_CYC = `PSCR_QUAL_CYC
) (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_in,
  // register port
  input wire logic [`PSCR_ADDR_W-1:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  // oscillator status from the analog side
  input wire logic osc_running_in,
  // synthesizer settings
  output logic [5:0] loop_multiplier_out,
  output logic [1:0] osc_gain_range_out,
  output logic [3:0] ref_divisor_out,
  output logic [1:0] filter_range_out,
  output logic ref_is_ext_out,
  output logic [4:0] pll_divisor_out,
  output logic bus_from_loop_out,
  // status
  output logic lock_out,
  output logic osc_qualified_out
);
  localparam int CNT_W = $clog2(LOCK_CYC + 1);

  if (LOCK_CYC < 1 || QUAL_CYC < 1 || QUAL_CYC > LOCK_CYC) begin : g_bad_cnt
    $error("pscr_synth_cfg: bad settle counts");
  end

  pscr_pkg::pscr_byte_t synth_r;
  pscr_pkg::pscr_byte_t synth_nxt;
  pscr_pkg::pscr_byte_t ref_div_r;
  pscr_pkg::pscr_byte_t ref_div_nxt;
  pscr_pkg::pscr_byte_t post_div_r;
  pscr_pkg::pscr_byte_t post_div_nxt;
  pscr_pkg::pscr_byte_t clksel_r;
  pscr_pkg::pscr_byte_t clksel_nxt;
  pscr_pkg::pscr_byte_t osc_r;
  pscr_pkg::pscr_byte_t osc_nxt;
  pscr_pkg::pscr_byte_t protect_r;
  pscr_pkg::pscr_byte_t protect_nxt;
  pscr_pkg::pscr_byte_t rdata_r;
  pscr_pkg::pscr_byte_t rdata_nxt;
  pscr_pkg::pscr_state_e state_r;
  pscr_pkg::pscr_state_e state_nxt;
  logic lock_r;
  logic lock_nxt;
  logic upos_r;
  logic upos_nxt;
  logic [CNT_W-1:0] qual_r;
  logic [CNT_W-1:0] qual_nxt;
  logic [4:0] pdiv_r;
  logic [4:0] pdiv_nxt;
  logic [1:0] filt_r;
  logic [1:0] filt_nxt;
  logic lock_force_r;
  logic lock_force_nxt;
  logic hit_synth;
  logic hit_ref_div;
  logic hit_post_div;
  logic hit_clksel;
  logic hit_osc;
  logic hit_protect;
  logic hit_locksim;
  logic cfg_ok;
  logic sel;
  logic wr_synth;
  logic wr_ref_div;
  logic wr_post_div;
  logic wr_clksel;
  logic wr_osc;
  logic wr_protect;
  logic wr_locksim;
  logic cfg_wr;
  logic qual_run;
  logic settle_load;
  logic settle_done;

  assign hit_synth = addr_in == `PSCR_OFF_SYNTH;
  assign hit_ref_div = addr_in == `PSCR_OFF_REF_DIV;
  assign hit_post_div = addr_in == `PSCR_OFF_POST_DIV;
  assign hit_clksel = addr_in == `PSCR_OFF_CLKSEL;
  assign hit_osc = addr_in == `PSCR_OFF_OSC;
  assign hit_protect = addr_in == `PSCR_OFF_PROTECT;
  assign hit_locksim = addr_in == `PSCR_OFF_LOCKSIM;

  assign sel = clksel_r[`PSCR_SEL_BIT];
  assign cfg_ok = !protect_r[`PSCR_PROTECT_BIT] && sel;
  assign wr_synth = wr_in && hit_synth && cfg_ok;
  assign wr_ref_div = wr_in && hit_ref_div && cfg_ok;
  assign wr_post_div = wr_in && hit_post_div && sel;
  assign wr_clksel = wr_in && hit_clksel && !protect_r[`PSCR_PROTECT_BIT];
  assign wr_osc = wr_in && hit_osc && !protect_r[`PSCR_PROTECT_BIT];
  assign wr_protect = wr_in && hit_protect;
  assign wr_locksim = wr_in && hit_locksim;
  assign cfg_wr = wr_synth || wr_ref_div;

  // register writes
  always_comb begin
    synth_nxt = synth_r;
    ref_div_nxt = ref_div_r;
    post_div_nxt = post_div_r;
    clksel_nxt = clksel_r;
    osc_nxt = osc_r;
    protect_nxt = protect_r;
    lock_force_nxt = lock_force_r;
    if (wr_synth) begin
      synth_nxt = wdata_in;
    end
    if (wr_ref_div) begin
      ref_div_nxt = {wdata_in[7:6], 2'b00, wdata_in[3:0]};
    end
    if (wr_post_div) begin
      post_div_nxt = {3'b000, wdata_in[4:0]};
    end
    if (wr_clksel) begin
      clksel_nxt = {wdata_in[7], 7'h00};
    end
    if (wr_osc) begin
      osc_nxt = {wdata_in[7], 7'h00};
    end
    if (wr_protect) begin
      protect_nxt = {7'h00, wdata_in[0]};
    end
    if (wr_locksim) begin
      lock_force_nxt = wdata_in[0];
    end
  end

  // lock and oscillator qualification
  assign settle_load = (state_r == pscr_pkg::PSCR_ST_IDLE) || cfg_wr;
  // losing lock also drops the qualified status
  assign qual_run = lock_r && !lock_force_r && osc_r[`PSCR_EXT_OSC_BIT]
    && osc_running_in;

  pscr_settle_cnt #(
    .CNT_W(CNT_W)
  ) u_settle (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .load_in(settle_load),
    .value_in(CNT_W'(LOCK_CYC)),
    .done_out(settle_done)
  );

  always_comb begin
    state_nxt = state_r;
    lock_nxt = lock_r;
    upos_nxt = upos_r;
    qual_nxt = qual_r;
    case (state_r)
      pscr_pkg::PSCR_ST_IDLE: begin
        state_nxt = pscr_pkg::PSCR_ST_SETTLE;
      end
      pscr_pkg::PSCR_ST_SETTLE: begin
        if (settle_done && !cfg_wr) begin
          state_nxt = pscr_pkg::PSCR_ST_LOCKED;
          lock_nxt = 1'b1;
        end
      end
      pscr_pkg::PSCR_ST_LOCKED: begin
        lock_nxt = 1'b1;
      end
      default: begin
        state_nxt = pscr_pkg::PSCR_ST_IDLE;
      end
    endcase
    if (lock_force_r) begin
      lock_nxt = 1'b0;
    end
    // qualification needs lock and a running oscillator
    if (qual_run) begin
      if (qual_r == CNT_W'(QUAL_CYC)) begin
        upos_nxt = 1'b1;
      end else begin
        qual_nxt = qual_r + 1'b1;
      end
    end else begin
      qual_nxt = '0;
      upos_nxt = 1'b0;
    end
    if (cfg_wr) begin
      state_nxt = pscr_pkg::PSCR_ST_SETTLE;
      lock_nxt = 1'b0;
      upos_nxt = 1'b0;
      qual_nxt = '0;
    end
  end

  // effective dividers and filter
  always_comb begin
    pdiv_nxt = lock_nxt ? post_div_nxt[4:0] : `PSCR_UNLOCK_DIV;
    filt_nxt = osc_nxt[`PSCR_EXT_OSC_BIT] ? ref_div_nxt[7:6]
      : `PSCR_FILT_FIXED;
  end

  // read data
  always_comb begin
    rdata_nxt = 8'h00;
    if (rd_in) begin
      case (addr_in)
        `PSCR_OFF_SYNTH: rdata_nxt = synth_r;
        `PSCR_OFF_REF_DIV: rdata_nxt = ref_div_r;
        `PSCR_OFF_POST_DIV: rdata_nxt = post_div_r;
        `PSCR_OFF_FLAGS: begin
          rdata_nxt[`PSCR_LOCK_BIT] = lock_r;
          rdata_nxt[`PSCR_QUALIFIED_BIT] = upos_r;
        end
        `PSCR_OFF_CLKSEL: rdata_nxt = clksel_r;
        `PSCR_OFF_OSC: rdata_nxt = osc_r;
        `PSCR_OFF_PROTECT: rdata_nxt = protect_r;
        `PSCR_OFF_LOCKSIM: rdata_nxt = {7'h00, lock_force_r};
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  // register file
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      synth_r <= `PSCR_RST_SYNTH;
      ref_div_r <= `PSCR_RST_REF_DIV;
      post_div_r <= `PSCR_RST_POST_DIV;
      clksel_r <= `PSCR_RST_CLKSEL;
      osc_r <= `PSCR_RST_OSC;
      protect_r <= `PSCR_RST_PROTECT;
      lock_force_r <= 1'b0;
    end else begin
      synth_r <= synth_nxt;
      ref_div_r <= ref_div_nxt;
      post_div_r <= post_div_nxt;
      clksel_r <= clksel_nxt;
      osc_r <= osc_nxt;
      protect_r <= protect_nxt;
      lock_force_r <= lock_force_nxt;
    end
  end

  // lock state
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      state_r <= pscr_pkg::PSCR_ST_IDLE;
      lock_r <= 1'b0;
      upos_r <= 1'b0;
      qual_r <= '0;
    end else begin
      state_r <= state_nxt;
      lock_r <= lock_nxt;
      upos_r <= upos_nxt;
      qual_r <= qual_nxt;
    end
  end

  // effective dividers
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      pdiv_r <= `PSCR_UNLOCK_DIV;
      filt_r <= `PSCR_FILT_FIXED;
    end else begin
      pdiv_r <= pdiv_nxt;
      filt_r <= filt_nxt;
    end
  end

  // read data register
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  // analog settings straight from flops
  assign rdata_out = rdata_r;
  assign loop_multiplier_out = synth_r[5:0];
  assign osc_gain_range_out = synth_r[7:6];
  assign ref_divisor_out = ref_div_r[3:0];
  assign ref_is_ext_out = osc_r[`PSCR_EXT_OSC_BIT];
  assign filter_range_out = filt_r;
  assign pll_divisor_out = pdiv_r;
  assign bus_from_loop_out = clksel_r[`PSCR_SEL_BIT];
  assign lock_out = lock_r;
  assign osc_qualified_out = upos_r;
endmodule

/* sim/pscr_synth_cfg_properties.sv */
// port assertions for the synthesizer configuration block
module pscr_props (
  // clock, reset and register port
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic [9:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [7:0] rdata_out,
  // settings and status
  input wire logic osc_running_in,
  input wire logic [5:0] loop_multiplier_out,
  input wire logic [1:0] osc_gain_range_out,
  input wire logic [3:0] ref_divisor_out,
  input wire logic [1:0] filter_range_out,
  input wire logic ref_is_ext_out,
  input wire logic [4:0] pll_divisor_out,
  input wire logic bus_from_loop_out,
  input wire logic lock_out,
  input wire logic osc_qualified_out
);
  logic protect_r;
  logic protect_nxt;
  logic syn;
  logic acc;
  assign syn = wr_in && addr_in == 10'h034;
  assign acc = wr_in && !protect_r && bus_from_loop_out
    && (syn || addr_in == 10'h035);
  always_comb begin
    protect_nxt = wr_in && addr_in == 10'h2fb ? wdata_in[0] : protect_r;
  end
  always_ff @(posedge ref_clk_in) begin
    protect_r <= rst_in ? 1'b0 : protect_nxt;
  end
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  a_mult_take: assert property (acc && syn |=>
    {osc_gain_range_out, loop_multiplier_out} == $past(wdata_in))
    else $error("multiplier lost");
  a_mult_guard: assert property (syn && !acc |=>
    $stable({osc_gain_range_out, loop_multiplier_out}))
    else $error("guarded write taken");
  a_status_clear: assert property (acc |=>
    !lock_out && !osc_qualified_out)
    else $error("status kept");
  a_select_guard: assert property (
    wr_in && addr_in == 10'h039 && protect_r |=> $stable(bus_from_loop_out))
    else $error("select changed");
  a_post_take: assert property (
    wr_in && addr_in == 10'h036 && bus_from_loop_out && lock_out ##1
    lock_out |-> pll_divisor_out == $past(wdata_in[4:0]))
    else $error("post divisor lost");
  a_unlock_div: assert property (
    !lock_out && !$past(lock_out) |-> pll_divisor_out == 5'h03)
    else $error("unlocked divisor");
  a_filter_fixed: assert property (
    !ref_is_ext_out |-> filter_range_out == 2'b00)
    else $error("filter not fixed");
  a_read_idle: assert property (!rd_in |=> rdata_out == 8'h00)
    else $error("read data stray");
  a_qual_lock: assert property (osc_qualified_out |-> lock_out)
    else $error("qualified without lock");
endmodule

bind pscr_synth_cfg pscr_props u_props (.ref_clk_in, .rst_in, .addr_in,
  .wdata_in, .wr_in, .rd_in, .rdata_out, .osc_running_in,
  .loop_multiplier_out, .osc_gain_range_out, .ref_divisor_out,
  .filter_range_out, .ref_is_ext_out, .pll_divisor_out, .bus_from_loop_out,
  .lock_out, .osc_qualified_out);

/* sim/pscr_synth_cfg_bench.sv */
// self-checking bench for the synthesizer configuration block
module pscr_synth_cfg_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic osc_running_in = 1'b0;
  logic [9:0] addr_in = '0;
  logic [9:0] a;
  logic [7:0] wdata_in = '0;
  logic [7:0] rdata_out, d, r, sv;
  logic [5:0] mul;
  logic [4:0] pdv;
  logic [3:0] rdv;
  logic [1:0] gain, filt;
  logic ext, sel, lock, qual;
  int errors = 0;
  int checked = 0;
  pscr_synth_cfg #(.LOCK_CYC(20), .QUAL_CYC(4)) u_dut (.ref_clk_in, .rst_in,
    .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out, .osc_running_in,
    .loop_multiplier_out(mul), .osc_gain_range_out(gain),
    .ref_divisor_out(rdv), .filter_range_out(filt), .ref_is_ext_out(ext),
    .pll_divisor_out(pdv), .bus_from_loop_out(sel), .lock_out(lock),
    .osc_qualified_out(qual));
  function automatic logic [7:0] fold(input logic [9:0] a,
    input logic [7:0] v);
    return a == 10'h035 ? v & 8'hcf : a == 10'h036 ? v & 8'h1f : v;
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("FAIL %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [9:0] a, input logic [7:0] v);
    addr_in <= a;
    wdata_in <= v;
    wr_in <= 1'b1;
    @(posedge ref_clk_in);
    wr_in <= 1'b0;
    @(posedge ref_clk_in);
    #1;
  endtask
  task automatic rd(input logic [9:0] a, output logic [7:0] v);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge ref_clk_in);
    rd_in <= 1'b0;
    #1;
    v = rdata_out;
    @(posedge ref_clk_in);
    #1;
  endtask
  task automatic wrap_up;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic wait_lock;
    for (int n = 0; n < 100 && lock !== 1'b1; n++) begin
      @(posedge ref_clk_in);
    end
    chk({7'h0, lock}, 8'h01);
    if (lock !== 1'b1) begin
      wrap_up();
    end
  endtask
  initial begin
    forever #2.5 ref_clk_in = ~ref_clk_in;
  end
  initial begin
    void'($urandom(32'hd8ae_3e7e));
    repeat (10) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    rd(10'h034, r);
    chk(r, 8'h5f);
    rd(10'h3ff, r);
    chk(r, 8'h00);
    chk({sel, 2'h0, pdv}, 8'h83);
    $display("reset test done");
    wait_lock();
    for (int i = 0; i < 3; i++) begin
      a = 10'h036 - 10'(i);
      d = 8'($urandom) & 8'h7f;
      wr(a, d);
      chk({7'h0, lock}, {7'h0, i == 0});
      rd(a, r);
      chk(r, fold(a, d));
    end
    chk({gain, mul}, d);
    chk({3'h0, pdv}, 8'h03);
    $display("write test done");
    rd(10'h034, sv);
    rd(10'h036, d);
    wr(10'h2fb, 8'h01);
    wr(10'h034, ~sv);
    wr(10'h039, 8'h00);
    chk({7'h0, sel}, 8'h01);
    wr(10'h2fb, 8'h00);
    wr(10'h039, 8'h00);
    chk({7'h0, sel}, 8'h00);
    wr(10'h034, ~sv);
    wr(10'h036, ~d);
    rd(10'h034, r);
    chk(r, sv);
    rd(10'h036, r);
    chk(r, d);
    wr(10'h039, 8'h80);
    chk({7'h0, sel}, 8'h01);
    $display("guard test done");
    osc_running_in <= 1'b1;
    wr(10'h2fa, 8'h80);
    d = 8'($urandom);
    wr(10'h035, d);
    chk({filt, ext, 1'b0, rdv}, {d[7:6], 2'b10, d[3:0]});
    chk({3'h0, ext, rdv}, {4'h1, d[3:0]});
    wait_lock();
    repeat (8) @(posedge ref_clk_in);
    rd(10'h037, r);
    chk(r, 8'h09);
    chk({7'h0, qual}, 8'h01);
    wr(10'h2fd, 8'h01);
    chk({6'h0, lock, qual}, 8'h00);
    wr(10'h2fd, 8'h00);
    chk({7'h0, lock}, 8'h01);
    wr(10'h2fa, 8'h00);
    chk({6'h0, filt}, 8'h00);
    $display("oscillator test done");
    wrap_up();
  end
endmodule
